// ===== common/amp_regs_pkg.sv
package amp_regs_pkg;
  localparam logic [7:0] OFS_PIN_INV = 8'h66;
  localparam logic [7:0] OFS_IDENT = 8'h67;
  localparam logic [7:0] OFS_PWR_STATE = 8'h68;
  localparam logic [7:0] OFS_MUTE_STAT = 8'h69;
  localparam logic [7:0] OFS_PHASE_CTRL = 8'h6a;
  localparam logic [7:0] OFS_SS_CTRL0 = 8'h6b;
  localparam logic [7:0] RST_REG = 8'h00;
  // Identification value is arbitrary.
  localparam logic [7:0] IDENT_CODE = 8'h5a;
  localparam int INV_MSB = 2;
  localparam int MUTE_RIGHT_BIT = 1;
  localparam int MUTE_LEFT_BIT = 0;
  localparam int PH_SEL_MSB = 3;
  localparam int PH_SEL_LSB = 2;
  localparam int SYNC_SEL_BIT = 1;
  localparam int SYNC_EN_BIT = 0;
  localparam int PRE_DIV_BIT = 5;
  localparam int MANUAL_BIT = 4;
  localparam int RDM_EN_BIT = 1;
  localparam int TRI_EN_BIT = 0;
  localparam logic [2:0] PHASE_STEP_45 = 3'h1;
  typedef enum logic [1:0] {
    PS_DEEP_SLEEP = 2'b00,
    PS_SLEEP = 2'b01,
    PS_HIZ = 2'b10,
    PS_PLAY = 2'b11
  } power_state_t;
endpackage

// ===== hdl/pin_invert.sv
`timescale 1ns/1ns
`default_nettype none
module pin_invert (
  // Clock and control
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_en,
  // Pin data
  input wire logic src_level,
  input wire logic invert,
  output logic pin_out
);
  logic pin_reg;
  logic pin_next;

  // Inversion sits after source selection so every function is affected.
  assign pin_next = src_level ^ invert;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_reg <= 1'b0;
    end else if (clk_en) begin
      pin_reg <= pin_next;
    end
  end

  assign pin_out = pin_reg;

  AST_INV_APPLIED: assert property (
    @(posedge clk_sys) disable iff (srst)
    $past(clk_en) && !$past(srst) |->
    pin_out == ($past(src_level) ^ $past(invert)))
    else $error("pin level does not follow source xor invert");
endmodule
`default_nettype wire

// ===== hdl/amp_misc_ctrl_status_regs.sv
`timescale 1ns/1ns
`default_nettype none
module amp_misc_ctrl_status_regs (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_en,
  // Control port register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Device state inputs
  input wire logic [1:0] power_state,
  input wire logic right_muted_flag,
  input wire logic left_muted_flag,
  // Pin sources after selection and resulting pin levels
  input wire logic [2:0] pin_src_level,
  output logic [2:0] pin_level,
  // Ramp phase synchronisation
  input wire logic [2:0] sync_pin_async,
  input wire logic [1:0] sync_pin_index,
  input wire logic internal_sync,
  output logic [2:0] ramp_phase_offset,
  output logic phase_sync_pulse,
  // Spread-spectrum controller controls
  output logic ss_manual_mode,
  output logic ss_clk_pll_div2,
  output logic ss_random_en,
  output logic ss_triangle_en
);
  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [7:0] pin_output_invert_reg;
  logic [7:0] ramp_phase_control_reg;
  logic [7:0] spread_spectrum_control0_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [2:0] sync_meta_reg;
  logic [2:0] sync_pin_reg;
  logic sync_src_reg;
  logic sync_pulse_reg;

  wire wr_inv = reg_wr && reg_addr == amp_regs_pkg::OFS_PIN_INV;
  wire wr_phase = reg_wr && reg_addr == amp_regs_pkg::OFS_PHASE_CTRL;
  wire wr_ss = reg_wr && reg_addr == amp_regs_pkg::OFS_SS_CTRL0;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_output_invert_reg <= amp_regs_pkg::RST_REG;
      ramp_phase_control_reg <= amp_regs_pkg::RST_REG;
      spread_spectrum_control0_reg <= amp_regs_pkg::RST_REG;
    end else if (clk_en) begin
      if (wr_inv) begin
        pin_output_invert_reg <= reg_wdata;
      end
      if (wr_phase) begin
        ramp_phase_control_reg <= reg_wdata;
      end
      if (wr_ss) begin
        spread_spectrum_control0_reg <= reg_wdata;
      end
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  wire [7:0] mute_word = {6'h00, right_muted_flag, left_muted_flag};
  wire [7:0] state_code = {6'h00, power_state};

  always_comb begin
    case (reg_addr)
      amp_regs_pkg::OFS_PIN_INV: rdata_next = pin_output_invert_reg;
      amp_regs_pkg::OFS_IDENT: rdata_next = amp_regs_pkg::IDENT_CODE;
      amp_regs_pkg::OFS_PWR_STATE: rdata_next = state_code;
      amp_regs_pkg::OFS_MUTE_STAT: rdata_next = mute_word;
      amp_regs_pkg::OFS_PHASE_CTRL: rdata_next = ramp_phase_control_reg;
      amp_regs_pkg::OFS_SS_CTRL0: rdata_next = spread_spectrum_control0_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_reg <= 8'h00;
    end else if (clk_en && reg_rd) begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ------------------------------------------------------------------
  // Pin inversion
  // ------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi <= amp_regs_pkg::INV_MSB; gi++) begin : g_inv
      pin_invert u_inv (
        .clk_sys(clk_sys),
        .srst(srst),
        .clk_en(clk_en),
        .src_level(pin_src_level[gi]),
        .invert(pin_output_invert_reg[gi]),
        .pin_out(pin_level[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // Ramp phase and synchronisation
  // ------------------------------------------------------------------
  wire [1:0] phase_sel = ramp_phase_control_reg[amp_regs_pkg::PH_SEL_MSB:
                                                amp_regs_pkg::PH_SEL_LSB];
  wire sync_en = ramp_phase_control_reg[amp_regs_pkg::SYNC_EN_BIT];
  wire sync_int = ramp_phase_control_reg[amp_regs_pkg::SYNC_SEL_BIT];

  // Offset expressed in units of 45 degrees.
  assign ramp_phase_offset = 3'(phase_sel) * amp_regs_pkg::PHASE_STEP_45;

  // Pin index 0 means no pin is routed, so the pin source stays idle.
  wire pin_sync = (sync_pin_index == 2'b00) ? 1'b0 :
                  sync_pin_reg[sync_pin_index - 2'b01];
  wire sync_src = sync_int ? internal_sync : pin_sync;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync_meta_reg <= 3'h0;
      sync_pin_reg <= 3'h0;
      sync_src_reg <= 1'b0;
      sync_pulse_reg <= 1'b0;
    end else if (clk_en) begin
      sync_meta_reg <= sync_pin_async;
      sync_pin_reg <= sync_meta_reg;
      sync_src_reg <= sync_src;
      sync_pulse_reg <= sync_en && sync_src && !sync_src_reg;
    end
  end

  assign phase_sync_pulse = sync_pulse_reg;

  // ------------------------------------------------------------------
  // Spread-spectrum controls
  // ------------------------------------------------------------------
  assign ss_manual_mode =
    spread_spectrum_control0_reg[amp_regs_pkg::MANUAL_BIT];
  // The pre-divider only matters in manual mode.
  assign ss_clk_pll_div2 = ss_manual_mode &&
    spread_spectrum_control0_reg[amp_regs_pkg::PRE_DIV_BIT];
  assign ss_random_en =
    spread_spectrum_control0_reg[amp_regs_pkg::RDM_EN_BIT];
  assign ss_triangle_en =
    spread_spectrum_control0_reg[amp_regs_pkg::TRI_EN_BIT];

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  AST_PWR_READ: assert property (
    @(posedge clk_sys) disable iff (srst)
    clk_en && reg_rd && reg_addr == amp_regs_pkg::OFS_PWR_STATE |=>
    reg_rdata == {6'h00, $past(power_state)})
    else $error("power state read wrong");
  AST_RIGHT_MUTE: assert property (
    @(posedge clk_sys) disable iff (srst)
    clk_en && reg_rd && reg_addr == amp_regs_pkg::OFS_MUTE_STAT |=>
    reg_rdata[1] == $past(right_muted_flag))
    else $error("right mute bit wrong");
  AST_LEFT_MUTE: assert property (
    @(posedge clk_sys) disable iff (srst)
    clk_en && reg_rd && reg_addr == amp_regs_pkg::OFS_MUTE_STAT |=>
    reg_rdata[0] == $past(left_muted_flag) && reg_rdata[7:2] == 6'h00)
    else $error("left mute bit wrong");
  AST_IDENT_READ: assert property (
    @(posedge clk_sys) disable iff (srst)
    clk_en && reg_rd && reg_addr == amp_regs_pkg::OFS_IDENT |=>
    reg_rdata == amp_regs_pkg::IDENT_CODE)
    else $error("identification read wrong");
  AST_PHASE: assert property (
    @(posedge clk_sys) disable iff (srst)
    clk_en && wr_phase |=> ramp_phase_offset == 3'($past(reg_wdata[3:2])))
    else $error("phase offset wrong");
  // A frozen clock enable holds the pulse, so only enabled cycles count.
  AST_SYNC_OFF: assert property (
    @(posedge clk_sys) disable iff (srst)
    clk_en && !sync_en |=> !phase_sync_pulse)
    else $error("sync pulse while disabled");
  AST_SYNC_ONE: assert property (
    @(posedge clk_sys) disable iff (srst)
    clk_en && phase_sync_pulse |=> !phase_sync_pulse)
    else $error("sync pulse longer than one cycle");
  AST_SYNC_RESET: assert property (
    @(posedge clk_sys) disable iff (srst)
    $past(srst) |-> !sync_en && !phase_sync_pulse)
    else $error("sync enabled after reset");
  AST_SYNC_SRC: assert property (
    @(posedge clk_sys) disable iff (srst)
    clk_en && sync_en && sync_int && internal_sync && !sync_src_reg |=>
    phase_sync_pulse)
    else $error("internal sync not taken");
  AST_PIN_SYNC: assert property (
    @(posedge clk_sys) disable iff (srst)
    clk_en && sync_en && !sync_int && sync_pin_index == 2'b10 &&
    sync_pin_reg[1] && !sync_src_reg |=> phase_sync_pulse)
    else $error("pin sync not taken");
  AST_PREDIV: assert property (
    @(posedge clk_sys) disable iff (srst)
    clk_en && wr_ss |=>
    ss_clk_pll_div2 == ($past(reg_wdata[5]) && $past(reg_wdata[4])))
    else $error("pre-divide select wrong");
  AST_SS_WRITE: assert property (
    @(posedge clk_sys) disable iff (srst)
    clk_en && wr_ss |=> ss_random_en == $past(reg_wdata[1]) &&
    ss_triangle_en == $past(reg_wdata[0]) &&
    ss_manual_mode == $past(reg_wdata[4]))
    else $error("spread control not applied");
  AST_SS_RESET: assert property (
    @(posedge clk_sys) disable iff (srst)
    $past(srst) |-> !ss_random_en && !ss_triangle_en)
    else $error("spread modulation enabled after reset");
  COV_SYNC: cover property (@(posedge clk_sys) phase_sync_pulse);
  COV_PIN_SYNC: cover property (@(posedge clk_sys)
    phase_sync_pulse && !sync_int);
  COV_PLAY: cover property (@(posedge clk_sys)
    power_state == amp_regs_pkg::PS_PLAY);
  COV_DIV2: cover property (@(posedge clk_sys) ss_clk_pll_div2);
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [1:0] power_state = 2'h0;
  logic right_muted_flag = 1'b0;
  logic left_muted_flag = 1'b0;
  logic [2:0] pin_src_level = 3'h0;
  logic [2:0] sync_pin_async = 3'h0;
  logic [1:0] sync_pin_index = 2'h0;
  logic internal_sync = 1'b0;
  logic [7:0] reg_rdata;
  logic [2:0] pin_level, ramp_phase_offset;
  logic phase_sync_pulse, ss_manual_mode, ss_clk_pll_div2;
  logic ss_random_en, ss_triangle_en;
  logic [7:0] ss_v [6] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h02, 8'h01};
  int n_fail = 0;
  int num_checks = 0;
  int seen;

  amp_misc_ctrl_status_regs dut (
    .clk_sys, .srst, .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .power_state, .right_muted_flag, .left_muted_flag,
    .pin_src_level, .pin_level, .sync_pin_async, .sync_pin_index,
    .internal_sync, .ramp_phase_offset, .phase_sync_pulse, .ss_manual_mode,
    .ss_clk_pll_div2, .ss_random_en, .ss_triangle_en
  );

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  // Every drive lands 2 ns after a rising edge, clear of the sampling.
  task automatic step;
    @(posedge clk_sys);
    #2;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    step;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    step;
    reg_rd = 1'b1;
    reg_addr = a;
    step;
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask

  task automatic count_pulses(input int n);
    seen = 0;
    repeat (n) begin
      step;
      if (phase_sync_pulse === 1'b1) seen++;
    end
  endtask

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys);
    #2;
    srst = 1'b0;
    rd(amp_regs_pkg::OFS_PIN_INV, amp_regs_pkg::RST_REG);
    rd(amp_regs_pkg::OFS_PHASE_CTRL, amp_regs_pkg::RST_REG);
    rd(amp_regs_pkg::OFS_SS_CTRL0, amp_regs_pkg::RST_REG);
    rd(amp_regs_pkg::OFS_IDENT, amp_regs_pkg::IDENT_CODE);
    wr(amp_regs_pkg::OFS_IDENT, 8'hff);
    rd(amp_regs_pkg::OFS_IDENT, amp_regs_pkg::IDENT_CODE);
    wr(amp_regs_pkg::OFS_PWR_STATE, 8'hff);
    rd(8'h70, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(amp_regs_pkg::OFS_PHASE_CTRL, {4'h0, i[1:0], 2'b00});
      chk({5'h00, ramp_phase_offset}, {6'h00, i[1:0]});
      power_state = i[1:0];
      rd(amp_regs_pkg::OFS_PWR_STATE, {6'h00, i[1:0]});
      {right_muted_flag, left_muted_flag} = i[1:0];
      rd(amp_regs_pkg::OFS_MUTE_STAT, {6'h00, i[1:0]});
    end
    for (int i = 0; i < 8; i++) begin
      wr(amp_regs_pkg::OFS_PIN_INV, {5'h15, i[2:0]});
      pin_src_level = 3'h6;
      step;
      step;
      chk({5'h00, pin_level}, {5'h00, 3'h6 ^ i[2:0]});
      rd(amp_regs_pkg::OFS_PIN_INV, {5'h15, i[2:0]});
    end
    pin_src_level = 3'h1;
    step;
    step;
    chk({5'h00, pin_level}, 8'h06);
    wr(amp_regs_pkg::OFS_PHASE_CTRL, 8'h03);
    internal_sync = 1'b1;
    step;
    chk({7'h00, phase_sync_pulse}, 8'h01);
    step;
    chk({7'h00, phase_sync_pulse}, 8'h00);
    internal_sync = 1'b0;
    wr(amp_regs_pkg::OFS_PHASE_CTRL, 8'h02);
    internal_sync = 1'b1;
    count_pulses(4);
    chk(seen[7:0], 8'h00);
    internal_sync = 1'b0;
    wr(amp_regs_pkg::OFS_PHASE_CTRL, 8'h01);
    sync_pin_index = 2'h2;
    sync_pin_async = 3'h1;
    count_pulses(6);
    chk(seen[7:0], 8'h00);
    sync_pin_async = 3'h3;
    count_pulses(6);
    chk(seen[7:0], 8'h01);
    foreach (ss_v[k]) begin
      wr(amp_regs_pkg::OFS_SS_CTRL0, ss_v[k]);
      chk({4'h0, ss_manual_mode, ss_clk_pll_div2, ss_random_en,
           ss_triangle_en}, {4'h0, ss_v[k][4], ss_v[k][5] & ss_v[k][4],
           ss_v[k][1], ss_v[k][0]});
      rd(amp_regs_pkg::OFS_SS_CTRL0, ss_v[k]);
    end
    clk_en = 1'b0;
    wr(amp_regs_pkg::OFS_SS_CTRL0, 8'h13);
    clk_en = 1'b1;
    rd(amp_regs_pkg::OFS_SS_CTRL0, 8'h01);
    wr(amp_regs_pkg::OFS_PHASE_CTRL, 8'h0f);
    srst = 1'b1;
    step;
    srst = 1'b0;
    rd(amp_regs_pkg::OFS_PHASE_CTRL, amp_regs_pkg::RST_REG);
    stop_test;
  end

  // A hang is cut short here and reported as a mismatch.
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    stop_test;
  end
endmodule
`default_nettype wire
